// ---- core/sdram_pkg.sv ----
// package: sdram geometry, command codes, mode fields and reset values
// Function
// - all sampling and launching on rising clock
// - four banks of 2048 rows, 256 words
// - activate picks bank and opens row
// - read or write takes start column
// - burst of 1, 2, 4, 8 or page
// - burst columns sequential or interleaved internally
// - read latency two or three cycles
// - auto precharge closes row after burst
// - new column command each cycle redirects burst
// - burst read with single word write mode
// - burst stop or precharge ends burst early
// - precharge one bank while another bursts
// - auto refresh and clock enable power down
// - precharge all flag closes every bank
// - chip select high ignores all commands
// - byte mask blocks write bytes, read drivers
// - clock enable low at an edge makes that same edge invalid
package sdram_pkg;
  localparam int BANK_W = 2;
  localparam int ROW_W = 11;
  localparam int COL_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int MASK_W = DATA_W / BYTE_W;
  localparam int BANKS = 4;
  localparam int ROWS = 2048;
  localparam int COLS = 256;
  localparam int WORD_ADDR_W = BANK_W + ROW_W + COL_W;
  localparam int WORDS = BANKS * ROWS * COLS;
  localparam int CNT_W = 9;
  localparam int REFRESH_W = 12;

  // mode word layout
  localparam int MODE_W = 11;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_BIT = 9;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_3 = 3'h3;
  localparam logic [CNT_W-1:0] WORDS_1 = 9'h001;
  localparam logic [CNT_W-1:0] WORDS_2 = 9'h002;
  localparam logic [CNT_W-1:0] WORDS_4 = 9'h004;
  localparam logic [CNT_W-1:0] WORDS_8 = 9'h008;
  localparam logic [CNT_W-1:0] WORDS_PAGE = 9'h100;

  // reset values: burst of one, sequential, latency two, burst writes
  localparam logic [MODE_W-1:0] MODE_RESET = 11'h020;
  localparam logic [REFRESH_W-1:0] REFRESH_RESET = 12'h000;

  // {ras_n, cas_n, we_n} with chip select low
  localparam logic [2:0] CODE_LOAD = 3'h0;
  localparam logic [2:0] CODE_REFRESH = 3'h1;
  localparam logic [2:0] CODE_PRECHARGE = 3'h2;
  localparam logic [2:0] CODE_ACTIVE = 3'h3;
  localparam logic [2:0] CODE_WRITE = 3'h4;
  localparam logic [2:0] CODE_READ = 3'h5;
  localparam logic [2:0] CODE_STOP = 3'h6;

  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_ACTIVE,
    CMD_READ,
    CMD_WRITE,
    CMD_STOP,
    CMD_PRECHARGE,
    CMD_REFRESH,
    CMD_LOAD
  } cmd_t;
endpackage : sdram_pkg

// ---- core/word_store.sv ----
// word store: single port array with byte writes and registered read
`timescale 1ns/1ps
module word_store (
  input wire logic clk,
  input wire logic en,
  input wire logic we,
  input wire logic [sdram_pkg::MASK_W-1:0] be,
  input wire logic [sdram_pkg::WORD_ADDR_W-1:0] addr,
  input wire logic [sdram_pkg::DATA_W-1:0] wdata,
  output logic [sdram_pkg::DATA_W-1:0] rdata
);
  logic [sdram_pkg::DATA_W-1:0] mem [sdram_pkg::WORDS];

  // array has no reset; read data holds when not read
  always_ff @(posedge clk)
  begin
    if (en)
    begin
      if (we)
      begin
        for (int i = 0; i < sdram_pkg::MASK_W; i++)
        begin
          if (be[i])
          begin
            mem[addr][i*sdram_pkg::BYTE_W +: sdram_pkg::BYTE_W] <=
              wdata[i*sdram_pkg::BYTE_W +: sdram_pkg::BYTE_W];
          end
        end
      end
      else
      begin
        rdata <= mem[addr];
      end
    end
  end
endmodule : word_store

// ---- core/sdram_x32_four_bank_interface.sv ----
// sdram device: command decode, banks, burst engine, read pipeline
`timescale 1ns/1ps
module sdram_x32_four_bank_interface (
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [sdram_pkg::BANK_W-1:0] bank_select,
  input wire logic [sdram_pkg::ROW_W-1:0] row_addr_lines,
  input wire logic [sdram_pkg::MASK_W-1:0] byte_mask,
  input wire logic [sdram_pkg::DATA_W-1:0] data_lines_in,
  output logic [sdram_pkg::DATA_W-1:0] data_lines_out,
  output logic [sdram_pkg::MASK_W-1:0] data_lines_oe,
  output logic power_down,
  output logic self_refresh
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic sdram_pkg::cmd_t decode_cmd(input logic cs_l,
                                                 input logic [2:0] code);
    sdram_pkg::cmd_t c;
    c = sdram_pkg::CMD_NOP;
    if (!cs_l)
    begin
      case (code)
        sdram_pkg::CODE_LOAD: c = sdram_pkg::CMD_LOAD;
        sdram_pkg::CODE_REFRESH: c = sdram_pkg::CMD_REFRESH;
        sdram_pkg::CODE_PRECHARGE: c = sdram_pkg::CMD_PRECHARGE;
        sdram_pkg::CODE_ACTIVE: c = sdram_pkg::CMD_ACTIVE;
        sdram_pkg::CODE_WRITE: c = sdram_pkg::CMD_WRITE;
        sdram_pkg::CODE_READ: c = sdram_pkg::CMD_READ;
        sdram_pkg::CODE_STOP: c = sdram_pkg::CMD_STOP;
        default: c = sdram_pkg::CMD_NOP;
      endcase
    end
    return c;
  endfunction : decode_cmd

  function automatic logic [sdram_pkg::CNT_W-1:0] burst_words(
    input logic [2:0] code);
    logic [sdram_pkg::CNT_W-1:0] w;
    w = sdram_pkg::WORDS_1;
    case (code)
      sdram_pkg::BL_2: w = sdram_pkg::WORDS_2;
      sdram_pkg::BL_4: w = sdram_pkg::WORDS_4;
      sdram_pkg::BL_8: w = sdram_pkg::WORDS_8;
      sdram_pkg::BL_PAGE: w = sdram_pkg::WORDS_PAGE;
      default: w = sdram_pkg::WORDS_1;
    endcase
    return w;
  endfunction : burst_words

  // interleave over a full page is undefined; it runs sequential there
  function automatic logic [sdram_pkg::COL_W-1:0] burst_col(
    input logic [sdram_pkg::COL_W-1:0] start,
    input logic [sdram_pkg::CNT_W-1:0] cnt,
    input logic [sdram_pkg::CNT_W-1:0] words,
    input logic ilv);
    logic [sdram_pkg::COL_W-1:0] span;
    logic [sdram_pkg::COL_W-1:0] off;
    span = sdram_pkg::COL_W'(words - sdram_pkg::WORDS_1);
    off = '0;
    if (words == sdram_pkg::WORDS_PAGE)
    begin
      off = sdram_pkg::COL_W'(start + cnt[sdram_pkg::COL_W-1:0]);
    end
    else if (ilv)
    begin
      off = (start ^ cnt[sdram_pkg::COL_W-1:0]) & span;
    end
    else
    begin
      off = sdram_pkg::COL_W'(start + cnt[sdram_pkg::COL_W-1:0]) & span;
    end
    if (words == sdram_pkg::WORDS_PAGE)
    begin
      return off;
    end
    return (start & ~span) | off;
  endfunction : burst_col

  ////////////////////////////////////////////////////////////////////////////
  sdram_pkg::cmd_t cmd;
  logic [sdram_pkg::COL_W-1:0] column_addr_lines;
  logic precharge_all_flag;
  assign cmd = decode_cmd(cs_n, {ras_n, cas_n, we_n});
  assign column_addr_lines = row_addr_lines[sdram_pkg::COL_W-1:0];
  assign precharge_all_flag = row_addr_lines[sdram_pkg::AP_BIT];

  logic [sdram_pkg::MODE_W-1:0] mode_q, mode_d;
  logic [sdram_pkg::BANKS-1:0] open_q, open_d;
  logic [sdram_pkg::ROW_W-1:0] row_q [sdram_pkg::BANKS];
  logic [sdram_pkg::ROW_W-1:0] row_d [sdram_pkg::BANKS];
  logic burst_act_q, burst_act_d;
  logic burst_wr_q, burst_wr_d;
  logic [sdram_pkg::BANK_W-1:0] burst_bank_q, burst_bank_d;
  logic [sdram_pkg::COL_W-1:0] start_q, start_d;
  logic [sdram_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [sdram_pkg::CNT_W-1:0] words_q, words_d;
  logic ilv_q, ilv_d;
  logic ap_q, ap_d;
  logic [sdram_pkg::REFRESH_W-1:0] refresh_row_q, refresh_row_d;

  logic mem_en, mem_we;
  logic [sdram_pkg::MASK_W-1:0] mem_be;
  logic [sdram_pkg::WORD_ADDR_W-1:0] mem_addr;
  logic [sdram_pkg::DATA_W-1:0] mem_rdata;
  logic [sdram_pkg::COL_W-1:0] cur_col;
  logic [sdram_pkg::CNT_W-1:0] new_words;
  logic redirect, hit_pre;

  ////////////////////////////////////////////////////////////////////////////
  // mode word
  always_comb
  begin
    mode_d = mode_q;
    if (clk_en && cmd == sdram_pkg::CMD_LOAD)
    begin
      mode_d = row_addr_lines[sdram_pkg::MODE_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_q <= sdram_pkg::MODE_RESET;
    end
    else
    begin
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // banks and burst engine; one data bus, so one burst at a time
  always_comb
  begin
    open_d = open_q;
    row_d = row_q;
    burst_act_d = burst_act_q;
    burst_wr_d = burst_wr_q;
    burst_bank_d = burst_bank_q;
    start_d = start_q;
    cnt_d = cnt_q;
    words_d = words_q;
    ilv_d = ilv_q;
    ap_d = ap_q;
    refresh_row_d = refresh_row_q;
    cur_col = burst_col(start_q, cnt_q, words_q, ilv_q);
    mem_addr = {burst_bank_q, row_q[burst_bank_q], cur_col};
    mem_en = 1'b0;
    mem_we = burst_wr_q;
    mem_be = ~byte_mask;
    new_words = burst_words(mode_q[sdram_pkg::MODE_BL_LSB +: 3]);
    if (cmd == sdram_pkg::CMD_WRITE && mode_q[sdram_pkg::MODE_WB_BIT])
    begin
      new_words = sdram_pkg::WORDS_1;
    end
    redirect = cmd == sdram_pkg::CMD_READ || cmd == sdram_pkg::CMD_WRITE;
    hit_pre = cmd == sdram_pkg::CMD_PRECHARGE &&
              (precharge_all_flag || bank_select == burst_bank_q);
    if (clk_en)
    begin
      if (burst_act_q && !redirect && cmd != sdram_pkg::CMD_STOP && !hit_pre)
      begin
        mem_en = 1'b1;
        cnt_d = cnt_q + sdram_pkg::WORDS_1;
        if (words_q != sdram_pkg::WORDS_PAGE &&
            cnt_q + sdram_pkg::WORDS_1 == words_q)
        begin
          burst_act_d = 1'b0;
          if (ap_q)
          begin
            open_d[burst_bank_q] = 1'b0;
          end
        end
      end
      case (cmd)
        sdram_pkg::CMD_ACTIVE:
        begin
          open_d[bank_select] = 1'b1;
          row_d[bank_select] = row_addr_lines;
        end
        sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE:
        begin
          // a pending self-close of another bank is honoured
          if (burst_act_q && ap_q && burst_bank_q != bank_select)
          begin
            open_d[burst_bank_q] = 1'b0;
          end
          mem_en = 1'b1;
          mem_we = cmd == sdram_pkg::CMD_WRITE;
          mem_addr = {bank_select, row_q[bank_select], column_addr_lines};
          burst_wr_d = cmd == sdram_pkg::CMD_WRITE;
          burst_bank_d = bank_select;
          start_d = column_addr_lines;
          cnt_d = sdram_pkg::WORDS_1;
          words_d = new_words;
          ilv_d = mode_q[sdram_pkg::MODE_BT_BIT];
          ap_d = row_addr_lines[sdram_pkg::AP_BIT];
          burst_act_d = new_words != sdram_pkg::WORDS_1;
          if (new_words == sdram_pkg::WORDS_1 &&
              row_addr_lines[sdram_pkg::AP_BIT])
          begin
            open_d[bank_select] = 1'b0;
          end
        end
        sdram_pkg::CMD_STOP:
        begin
          burst_act_d = 1'b0;
        end
        sdram_pkg::CMD_PRECHARGE:
        begin
          if (precharge_all_flag)
          begin
            open_d = '0;
          end
          else
          begin
            open_d[bank_select] = 1'b0;
          end
          if (hit_pre)
          begin
            burst_act_d = 1'b0;
          end
        end
        sdram_pkg::CMD_REFRESH:
        begin
          refresh_row_d = refresh_row_q + 12'h001;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      open_q <= '0;
      for (int b = 0; b < sdram_pkg::BANKS; b++)
      begin
        row_q[b] <= '0;
      end
      burst_act_q <= 1'b0;
      burst_wr_q <= 1'b0;
      burst_bank_q <= '0;
      start_q <= '0;
      cnt_q <= '0;
      words_q <= sdram_pkg::WORDS_1;
      ilv_q <= 1'b0;
      ap_q <= 1'b0;
      refresh_row_q <= sdram_pkg::REFRESH_RESET;
    end
    else
    begin
      open_q <= open_d;
      row_q <= row_d;
      burst_act_q <= burst_act_d;
      burst_wr_q <= burst_wr_d;
      burst_bank_q <= burst_bank_d;
      start_q <= start_d;
      cnt_q <= cnt_d;
      words_q <= words_d;
      ilv_q <= ilv_d;
      ap_q <= ap_d;
      refresh_row_q <= refresh_row_d;
    end
  end

  word_store store (
    .clk(clk),
    .en(mem_en),
    .we(mem_we),
    .be(mem_be),
    .addr(mem_addr),
    .wdata(data_lines_in),
    .rdata(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read pipeline: store adds one cycle, output flop one, extra stage at three
  logic rd_v1_q, rd_v1_d, rd_v2_q, rd_v2_d, out_valid_q, out_valid_d;
  logic [sdram_pkg::DATA_W-1:0] data2_q, data2_d, out_data_q, out_data_d;
  logic [sdram_pkg::MASK_W-1:0] mask_q, mask_d, oe_q, oe_d;
  logic lat3;
  assign lat3 = mode_q[sdram_pkg::MODE_CL_LSB +: 3] == sdram_pkg::CL_3;

  always_comb
  begin
    rd_v1_d = rd_v1_q;
    rd_v2_d = rd_v2_q;
    data2_d = data2_q;
    out_valid_d = out_valid_q;
    out_data_d = out_data_q;
    mask_d = mask_q;
    oe_d = oe_q;
    if (clk_en)
    begin
      rd_v1_d = mem_en && !mem_we;
      rd_v2_d = rd_v1_q;
      data2_d = mem_rdata;
      out_valid_d = lat3 ? rd_v2_q : rd_v1_q;
      out_data_d = lat3 ? data2_q : mem_rdata;
      mask_d = byte_mask;
      // mask acts two edges after it is sampled
      oe_d = {sdram_pkg::MASK_W{out_valid_d}} & ~mask_q;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_v1_q <= 1'b0;
      rd_v2_q <= 1'b0;
      data2_q <= '0;
      out_valid_q <= 1'b0;
      out_data_q <= '0;
      mask_q <= '0;
      oe_q <= '0;
    end
    else
    begin
      rd_v1_q <= rd_v1_d;
      rd_v2_q <= rd_v2_d;
      data2_q <= data2_d;
      out_valid_q <= out_valid_d;
      out_data_q <= out_data_d;
      mask_q <= mask_d;
      oe_q <= oe_d;
    end
  end

  assign data_lines_out = out_data_q;
  assign data_lines_oe = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // low power states follow clock enable; these alone run while it is low
  logic pd_q, pd_d, sr_q, sr_d;
  always_comb
  begin
    pd_d = pd_q;
    sr_d = sr_q;
    if (clk_en)
    begin
      pd_d = 1'b0;
      sr_d = 1'b0;
    end
    else if (!pd_q && !sr_q)
    begin
      if (cmd == sdram_pkg::CMD_REFRESH)
      begin
        sr_d = 1'b1;
      end
      else if (!burst_act_q && !rd_v1_q && !rd_v2_q)
      begin
        pd_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pd_q <= 1'b0;
      sr_q <= 1'b0;
    end
    else
    begin
      pd_q <= pd_d;
      sr_q <= sr_d;
    end
  end

  assign power_down = pd_q;
  assign self_refresh = sr_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  read_lat_two_a: assert property (
    (clk_en && cmd == sdram_pkg::CMD_READ && !lat3) ##1 clk_en
    |=> out_valid_q)
    else $error("read data not valid two cycles after read");
  read_lat_three_a: assert property (
    (clk_en && cmd == sdram_pkg::CMD_READ && lat3) ##1 clk_en[*2]
    |=> out_valid_q)
    else $error("read data not valid three cycles after read");
  cs_ignore_a: assert property (
    cs_n |=> $stable(mode_q) && $stable(refresh_row_q))
    else $error("state changed with chip select high");
  activate_row_a: assert property (
    (clk_en && cmd == sdram_pkg::CMD_ACTIVE)
    |=> open_q[$past(bank_select)] &&
        row_q[$past(bank_select)] == $past(row_addr_lines))
    else $error("activate did not open the row");
  precharge_all_a: assert property (
    (clk_en && cmd == sdram_pkg::CMD_PRECHARGE && precharge_all_flag)
    |=> open_q == 4'h0)
    else $error("precharge all left a bank open");
  write_capture_a: assert property (
    (clk_en && cmd == sdram_pkg::CMD_WRITE)
    |-> mem_en && mem_we && mem_be == ~byte_mask &&
        mem_addr[sdram_pkg::COL_W-1:0] == column_addr_lines)
    else $error("write data not taken on the command edge");
  burst_stop_a: assert property (
    (clk_en && cmd == sdram_pkg::CMD_STOP) |=> !burst_act_q)
    else $error("burst still active after stop");
  single_write_a: assert property (
    (clk_en && cmd == sdram_pkg::CMD_WRITE && mode_q[sdram_pkg::MODE_WB_BIT])
    |=> !burst_act_q)
    else $error("single write mode started a burst");
  clock_freeze_a: assert property (
    !clk_en |=> $stable(cnt_q) && $stable(open_q) && $stable(out_valid_q))
    else $error("state moved with clock enable low");
  read_mask_a: assert property (
    (clk_en && byte_mask[0]) ##1 clk_en |=> !data_lines_oe[0])
    else $error("masked byte driven on read");
  auto_close_a: assert property (
    $fell(burst_act_q) && $past(ap_q) && $past(clk_en) &&
    $past(cmd) == sdram_pkg::CMD_NOP |-> !open_q[$past(burst_bank_q)])
    else $error("auto precharge left the row open");
endmodule : sdram_x32_four_bank_interface

// ---- verification/mem_ctrl_model.sv ----
// controller model: drives commands, address, byte mask and write data
`timescale 1ns/1ps
module mem_ctrl_model (
  input wire logic clk,
  output logic clk_en,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [sdram_pkg::BANK_W-1:0] bank_select,
  output logic [sdram_pkg::ROW_W-1:0] row_addr_lines,
  output logic [sdram_pkg::MASK_W-1:0] byte_mask,
  output logic [sdram_pkg::DATA_W-1:0] data_lines_in
);
  initial
  begin
    clk_en = 1'h1;
    {cs_n, ras_n, cas_n, we_n} = 4'hF;
    bank_select = 2'h0;
    row_addr_lines = 11'h000;
    byte_mask = 4'h0;
    data_lines_in = 32'h0;
  end
  //////////////////////////////////////////////////////////////////////////
  // one command per edge; idle data lines toggle so stale data is useless
  task automatic cmd(input logic sel, input logic [2:0] code,
    input logic [1:0] b, input logic [10:0] a, input logic [3:0] mk,
    input logic [31:0] d, input logic dv);
    @(posedge clk);
    #1;
    cs_n = sel;
    {ras_n, cas_n, we_n} = code;
    bank_select = b;
    row_addr_lines = a;
    byte_mask = mk;
    data_lines_in = dv ? d : ~data_lines_in;
  endtask : cmd
  task automatic cke(input logic v);
    @(posedge clk);
    #1;
    clk_en = v;
  endtask : cke
endmodule : mem_ctrl_model

// ---- verification/sdram_x32_four_bank_interface_tb.sv ----
// testbench: bursts, masks, terminations and power states of the sdram
`timescale 1ns/1ps
module sdram_x32_four_bank_interface_tb;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic clk_en, cs_n, ras_n, cas_n, we_n;
  logic [1:0] bank_select;
  logic [10:0] row_addr_lines;
  logic [3:0] byte_mask, data_lines_oe;
  logic [31:0] data_lines_in, data_lines_out;
  logic power_down, self_refresh;
  int fails = 0;
  int comparisons = 0;
  int seed = 96432;
  int len_g = 1;
  logic ilv_g = 1'h0;
  logic cl3_g = 1'h0;
  logic wb_g = 1'h0;
  logic [10:0] row_of [4];
  logic [35:0] exp_q [$];
  logic [31:0] mem [int];
  logic [7:0] s;
  logic [2:0] bl_tab [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
  always #10 clk = ~clk;
  mem_ctrl_model ctl (.clk(clk), .clk_en(clk_en), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_select(bank_select),
    .row_addr_lines(row_addr_lines), .byte_mask(byte_mask),
    .data_lines_in(data_lines_in));
  sdram_x32_four_bank_interface uut (.clk(clk), .rst(rst), .clk_en(clk_en),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank_select(bank_select), .row_addr_lines(row_addr_lines),
    .byte_mask(byte_mask), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe),
    .power_down(power_down), .self_refresh(self_refresh));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] bm(input logic [3:0] m);
    for (int i = 0; i < 4; i++) bm[8*i+:8] = {8{m[i]}};
  endfunction : bm
  // burst column of word n; page bursts wrap on the whole row
  function automatic logic [7:0] col(input logic [7:0] st, input int n);
    logic [7:0] w;
    w = 8'(len_g - 1);
    if (len_g == 256) col = st + 8'(n);
    else if (ilv_g) col = (st & ~w) | ((st ^ 8'(n)) & w);
    else col = (st & ~w) | ((st + 8'(n)) & w);
  endfunction : col
  function automatic int key(input logic [1:0] b, input logic [7:0] c);
    key = int'({b, row_of[b], c});
  endfunction : key
  task automatic chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'h1)
    begin
      fails++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask : chk
  task automatic nop(input int n);
    repeat (n) ctl.cmd(1'h0, 3'h7, 2'h0, 11'h000, 4'h0, 32'h0, 1'h0);
  endtask : nop
  task automatic load(input logic [2:0] bl, input logic il,
    input logic [2:0] cl, input logic wb);
    len_g = bl == 3'h0 ? 1 : bl == 3'h1 ? 2 : bl == 3'h2 ? 4 :
      bl == 3'h3 ? 8 : 256;
    ilv_g = il;
    cl3_g = cl == sdram_pkg::CL_3;
    wb_g = wb;
    ctl.cmd(1'h0, sdram_pkg::CODE_LOAD, 2'h0, {1'h0, wb, 2'h0, cl, il, bl},
      4'h0, 32'h0, 1'h0);
    nop(2);
  endtask : load
  task automatic act(input logic [1:0] b, input logic [10:0] r);
    row_of[b] = r;
    ctl.cmd(1'h0, sdram_pkg::CODE_ACTIVE, b, r, 4'h0, 32'h0, 1'h0);
  endtask : act
  // single-word write mode keeps only the first word of the burst
  task automatic wr(input logic [1:0] b, input logic [7:0] st, input int n,
    input logic [3:0] mk);
    logic [31:0] d;
    int k;
    for (int i = 0; i < n; i++)
    begin
      d = $random(seed);
      k = key(b, col(st, i));
      if (i == 0 || !wb_g)
        mem[k] = mk == 4'h0 ? d : (mem[k] & bm(mk)) | (d & ~bm(mk));
      ctl.cmd(1'h0, i == 0 ? sdram_pkg::CODE_WRITE : 3'h7, b, {3'h0, st},
        mk, d, 1'h1);
    end
  endtask : wr
  // read mask reaches word 0 only at latency two
  task automatic rd(input logic [1:0] b, input logic [7:0] st, input int n,
    input logic [3:0] mk);
    for (int i = 0; i < n; i++)
      exp_q.push_back({(i == 0 && !cl3_g) ? ~mk : 4'hF,
        mem[key(b, col(st, i))]});
    ctl.cmd(1'h0, sdram_pkg::CODE_READ, b, {3'h0, st}, mk, 32'h0, 1'h0);
  endtask : rd
  task automatic term(input logic [1:0] b, input logic [7:0] st,
    input int n, input int g, input logic [2:0] code, input logic [1:0] pb,
    input logic [10:0] pa);
    rd(b, st, n, 4'h0);
    nop(g);
    ctl.cmd(1'h0, code, pb, pa, 4'h0, 32'h0, 1'h0);
    nop(10);
  endtask : term
  task automatic end_of_test;
    if (exp_q.size() != 0)
    begin
      fails++;
      $display("mismatch %0t read words missing", $time);
    end
    if (fails == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////
  // every driven word is compared, masked bytes only by their enable
  always @(posedge clk)
  begin
    if (!rst && data_lines_oe !== 4'h0)
    begin
      comparisons++;
      if (exp_q.size() == 0)
      begin
        fails++;
        $display("mismatch %0t unexpected read word", $time);
      end
      else if (data_lines_oe !== exp_q[0][35:32] || (data_lines_out &
        bm(data_lines_oe)) !== (exp_q[0][31:0] & bm(data_lines_oe)))
      begin
        fails++;
        $display("mismatch %0t read word or enable", $time);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  initial
  begin
    #(20 * 5000);
    fails++;
    $display("mismatch %0t watchdog expired", $time);
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clk);
    #1 rst = 1'h0;
    chk(data_lines_oe === 4'h0 && power_down === 1'h0, "reset outputs");
    act(2'h0, 11'h155);
    wr(2'h0, 8'h10, 1, 4'h0);
    rd(2'h0, 8'h10, 1, 4'h0);
    nop(4);
    for (int k = 0; k < 8; k++)
    begin
      load(bl_tab[k % 4], 1'(k / 4), ((k ^ (k >> 2)) & 1) ? 3'h3 : 3'h2,
        1'h0);
      act(2'(k), 11'($random(seed)));
      s = 8'($random(seed));
      wr(2'(k), s, len_g, 4'h0);
      rd(2'(k), s, len_g, 4'h0);
      nop(len_g + 4);
    end
    load(sdram_pkg::BL_PAGE, 1'h0, 3'h2, 1'h0);
    act(2'h1, 11'h2AA);
    wr(2'h1, 8'hFD, 5, 4'h0);
    nop(0);
    term(2'h1, 8'hFD, 4, 3, sdram_pkg::CODE_STOP, 2'h1, 11'h000);
    load(sdram_pkg::BL_1, 1'h0, 3'h2, 1'h0);
    wr(2'h1, 8'h20, 1, 4'h0);
    wr(2'h1, 8'h20, 1, 4'h5);
    ctl.cmd(1'h1, sdram_pkg::CODE_WRITE, 2'h1, 11'h020, 4'h0,
      $random(seed), 1'h1);
    rd(2'h1, 8'h20, 1, 4'h2);
    nop(4);
    load(sdram_pkg::BL_4, 1'h0, 3'h2, 1'h0);
    act(2'h2, 11'h0F0);
    wr(2'h2, 8'h40, 4, 4'h0);
    nop(2);
    load(sdram_pkg::BL_4, 1'h0, 3'h2, 1'h1);
    wr(2'h2, 8'h41, 4, 4'h0);
    nop(2);
    rd(2'h2, 8'h40, 1, 4'h0);
    rd(2'h2, 8'h42, 4, 4'h0);
    nop(6);
    for (int i = 0; i < 4; i++)
      exp_q.push_back({4'hF, mem[key(2'h2, col(8'h40, i))]});
    ctl.cmd(1'h0, sdram_pkg::CODE_READ, 2'h2, 11'h440, 4'h0, 32'h0,
      1'h0);
    nop(6);
    load(sdram_pkg::BL_8, 1'h0, sdram_pkg::CL_3, 1'h0);
    act(2'h3, 11'h3C3);
    wr(2'h3, 8'h08, 8, 4'h0);
    term(2'h3, 8'h08, 2, 1, sdram_pkg::CODE_PRECHARGE, 2'h3, 11'h000);
    act(2'h3, 11'h3C3);
    term(2'h3, 8'h08, 8, 2, sdram_pkg::CODE_PRECHARGE, 2'h0, 11'h000);
    term(2'h3, 8'h08, 2, 1, sdram_pkg::CODE_PRECHARGE, 2'h0, 11'h400);
    ctl.cmd(1'h0, sdram_pkg::CODE_REFRESH, 2'h0, 11'h000, 4'h0, 32'h0,
      1'h0);
    nop(4);
    ctl.cke(1'h0);
    nop(1);
    chk(power_down === 1'h1, "power down entry");
    ctl.cke(1'h1);
    nop(1);
    chk(power_down === 1'h0, "power down exit");
    ctl.cmd(1'h0, sdram_pkg::CODE_REFRESH, 2'h0, 11'h000, 4'h0, 32'h0,
      1'h0);
    ctl.cke(1'h0);
    nop(1);
    chk(self_refresh === 1'h1, "self refresh entry");
    ctl.cke(1'h1);
    nop(4);
    chk(self_refresh === 1'h0, "self refresh exit");
    end_of_test();
  end
endmodule : sdram_x32_four_bank_interface_tb
